// *** inc/dci_pkg.sv ***
// Constants and types of the debug command interpreter.
// Assumes one system clock; the serial debug pin is open drain with a pull-up.
package dci_pkg;

	localparam logic [7:0]  CMD_REV    = 8'h00;
	localparam logic [7:0]  CMD_STAT   = 8'h02;
	localparam logic [7:0]  CMD_RTC    = 8'h03;
	localparam logic [7:0]  CMD_WCTL   = 8'h04;
	localparam logic [7:0]  CMD_RCTL   = 8'h05;
	localparam logic [7:0]  CMD_WPC    = 8'h06;
	localparam logic [7:0]  CMD_RPC    = 8'h07;
	localparam logic [7:0]  CMD_WREG   = 8'h08;
	localparam logic [7:0]  CMD_RREG   = 8'h09;
	localparam logic [7:0]  CMD_STEP   = 8'h10;
	localparam logic [7:0]  CMD_STUFF  = 8'h11;
	localparam logic [7:0]  CMD_EXEC   = 8'h12;

	// Arbitrary value
	localparam logic [15:0] REV_VAL    = 16'h0100;
	localparam logic [7:0]  CTL_RST    = 8'h00;
	localparam logic [7:0]  CTL_WMASK  = 8'hE1;
	localparam int          CTL_HALT   = 7;
	localparam int          CTL_BRKEN  = 6;
	localparam logic [11:0] FLASH_LO   = 12'hFF8;
	localparam logic [11:0] FLASH_HI   = 12'hFFB;
	localparam logic [11:0] FLASH_CTL  = 12'hFF8;
	localparam logic [7:0]  MASS_ERASE = 8'h95;
	localparam logic [15:0] ONES16     = 16'hFFFF;
	localparam logic [7:0]  ONES8      = 8'hFF;
	localparam logic [8:0]  SIZE_256   = 9'h100;

	// Low run of the calibration character is eight bit periods
	localparam logic [14:0] CAL_MIN    = 15'h0040;
	localparam logic [14:0] CAL_MAX    = 15'h2000;
	localparam logic [14:0] BRK_MUL    = 15'h0009;
	localparam logic [5:0]  STOP_BIT   = 6'h09;
	// Four characters of ten bits each
	localparam logic [5:0]  BRK_LEN    = 6'h28;
	localparam logic [1:0]  PIN_RST    = 2'h3;
	localparam int          FIFO_W     = 8;
	localparam int          FIFO_D     = 8;

	typedef enum logic [5:0] {
		LK_CAL  = 6'h01,
		LK_IDLE = 6'h02,
		LK_RX   = 6'h04,
		LK_TX   = 6'h08,
		LK_BRK  = 6'h10,
		LK_WAIT = 6'h20
	} dci_lk_t;

	typedef enum logic [6:0] {
		CI_CMD  = 7'h01,
		CI_ARG  = 7'h02,
		CI_WR   = 7'h04,
		CI_RD   = 7'h08,
		CI_RDW  = 7'h10,
		CI_RSP  = 7'h20,
		CI_EXEC = 7'h40
	} dci_ci_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  data;
	} dci_reg_t;

	typedef struct packed {
		logic        pc_wr;
		logic        step;
		logic        stuff;
		logic        exec;
		logic [15:0] pc;
		logic [7:0]  op;
	} dci_cpu_t;

endpackage : dci_pkg

// *** src/dci_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides.
// Assumes a power-of-two depth and a single clock.
module dci_fifo #(
	parameter int W = dci_pkg::FIFO_W,
	parameter int D = dci_pkg::FIFO_D
) (
	input  wire logic         mclk_i,
	input  wire logic         srst_i,
	input  wire logic         flush_i,
	input  wire logic         in_vld_i,
	output logic              in_rdy_o,
	input  wire logic [W-1:0] in_dat_i,
	output logic              out_vld_o,
	input  wire logic         out_rdy_i,
	output logic [W-1:0]      out_dat_o
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_ff [D];
	logic [AW:0]  wp_ff;
	logic [AW:0]  rp_ff;
	logic         full;
	logic         empty;

	assign empty     = (wp_ff == rp_ff);
	assign full      = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
	assign in_rdy_o  = ~full;
	assign out_vld_o = ~empty;
	assign out_dat_o = mem_ff[rp_ff[AW-1:0]];

	always_ff @(posedge mclk_i) begin
		if (in_vld_i && !full) begin
			mem_ff[wp_ff[AW-1:0]] <= in_dat_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i || flush_i) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			if (in_vld_i && !full) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (out_rdy_i && !empty) begin
				rp_ff <= rp_ff + 1'b1;
			end
		end
	end
endmodule : dci_fifo

// *** src/dci_top.sv ***
// Debug command interpreter with its serial link, autobaud and answer FIFO.
// Assumes the CPU side runs on mclk_i; the debug pin is asynchronous.
module dci_top (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic        debug_pin_i,
	input  wire logic        read_protect_i,
	input  wire logic        bkpt_i,
	input  wire logic        exec_done_i,
	input  wire logic [7:0]  status_i,
	input  wire logic [15:0] pc_i,
	input  wire logic [7:0]  reg_rdata_i,
	output logic             debug_pin_o,
	output logic             debug_pin_oe_o,
	output logic [7:0]       ctl_o,
	output dci_pkg::dci_reg_t reg_o,
	output dci_pkg::dci_cpu_t cpu_o
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [1:0]        pin_sync_ff;
	logic              pin_d_ff;
	logic              pin_s;
	logic [14:0]       run_ff;
	dci_pkg::dci_lk_t  lk_ff;
	logic [10:0]       bitp_ff;
	logic [10:0]       tmr_ff;
	logic [14:0]       brk_lim_ff;
	logic [5:0]        bitn_ff;
	logic [9:0]        tsh_ff;
	logic [7:0]        rsh_ff;
	logic              oe_ff;
	logic              pin_o_ff;
	logic              rx_vld_ff;
	logic [7:0]        rx_dat_ff;
	logic              err_ff;
	logic              tick;
	logic              half;
	logic              err_now;
	logic              tx_take;
	logic              f_in_rdy;
	logic              f_out_vld;
	logic [7:0]        f_out_dat;

	dci_pkg::dci_ci_t  ci_ff;
	logic [7:0]        cmd_ff;
	logic [1:0]        need_ff;
	logic [15:0]       arg_ff;
	logic [8:0]        cnt_ff;
	logic [11:0]       addr_ff;
	logic [15:0]       rsp_ff;
	logic [1:0]        rsp_n_ff;
	dci_pkg::dci_reg_t reg_ff;
	dci_pkg::dci_cpu_t cpu_ff;
	logic [7:0]        ctl_ff;
	logic [7:0]        nxt_ctl;
	logic              halt_d_ff;
	logic [15:0]       rt_ff;
	logic              full;
	logic              last_arg;
	logic              wr_ok;
	logic              push;
	logic [7:0]        push_dat;

	////////////////////////////////////////////////////////////////////////////
	// Pin sampling and low-run measurement

	assign pin_s = pin_sync_ff[1];

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pin_sync_ff <= dci_pkg::PIN_RST;
			pin_d_ff    <= 1'b1;
		end else begin
			pin_sync_ff <= {pin_sync_ff[0], debug_pin_i};
			pin_d_ff    <= pin_s;
		end
	end

	// Saturates so a very long break cannot wrap into a valid calibration
	always_ff @(posedge mclk_i) begin
		if (srst_i || pin_s) begin
			run_ff <= '0;
		end else if (run_ff != 15'h7FFF) begin
			run_ff <= run_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial link: autobaud, receive, transmit, break

	assign tick = (tmr_ff == 11'h000);
	assign half = (tmr_ff == {1'b0, bitp_ff[10:1]});

	always_comb begin
		err_now = 1'b0;
		if (lk_ff == dci_pkg::LK_RX && tick && bitn_ff == dci_pkg::STOP_BIT && !pin_s) begin
			err_now = 1'b1;
		end
		// Own drive is seen back through the synchroniser well before mid-bit
		if (lk_ff == dci_pkg::LK_TX && half && !oe_ff && !pin_s) begin
			err_now = 1'b1;
		end
		if ((lk_ff == dci_pkg::LK_IDLE || lk_ff == dci_pkg::LK_RX || lk_ff == dci_pkg::LK_TX)
			&& run_ff >= brk_lim_ff) begin
			err_now = 1'b1;
		end
	end

	assign tx_take = (lk_ff == dci_pkg::LK_IDLE) && pin_s && f_out_vld && !err_now;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			lk_ff      <= dci_pkg::LK_CAL;
			bitp_ff    <= '0;
			tmr_ff     <= '0;
			brk_lim_ff <= 15'h7FFF;
			bitn_ff    <= '0;
			tsh_ff     <= 10'h3FF;
			rsh_ff     <= '0;
			oe_ff      <= 1'b0;
			rx_vld_ff  <= 1'b0;
			rx_dat_ff  <= '0;
			err_ff     <= 1'b0;
		end else begin
			rx_vld_ff <= 1'b0;
			err_ff    <= err_now;
			if (err_now) begin
				lk_ff   <= dci_pkg::LK_BRK;
				tmr_ff  <= bitp_ff - 11'h001;
				bitn_ff <= '0;
				oe_ff   <= 1'b1;
			end else begin
				case (lk_ff)
					dci_pkg::LK_CAL: begin
						oe_ff <= 1'b0;
						if (pin_s && !pin_d_ff && run_ff >= dci_pkg::CAL_MIN
							&& run_ff < dci_pkg::CAL_MAX) begin
							bitp_ff    <= run_ff[13:3];
							brk_lim_ff <= {4'h0, run_ff[13:3]} * dci_pkg::BRK_MUL
								+ {5'h00, run_ff[13:4]};
							lk_ff      <= dci_pkg::LK_IDLE;
						end
					end
					dci_pkg::LK_IDLE: begin
						if (!pin_s) begin
							lk_ff   <= dci_pkg::LK_RX;
							tmr_ff  <= {1'b0, bitp_ff[10:1]};
							bitn_ff <= '0;
						end else if (tx_take) begin
							lk_ff   <= dci_pkg::LK_TX;
							tsh_ff  <= {1'b1, f_out_dat, 1'b0};
							tmr_ff  <= bitp_ff - 11'h001;
							bitn_ff <= '0;
							oe_ff   <= 1'b1;
						end
					end
					dci_pkg::LK_RX: begin
						if (tick) begin
							tmr_ff  <= bitp_ff - 11'h001;
							bitn_ff <= bitn_ff + 1'b1;
							if (bitn_ff == 6'h00 && pin_s) begin
								lk_ff <= dci_pkg::LK_IDLE;
							end else if (bitn_ff == dci_pkg::STOP_BIT) begin
								lk_ff     <= dci_pkg::LK_IDLE;
								rx_vld_ff <= 1'b1;
								rx_dat_ff <= rsh_ff;
							end else if (bitn_ff != 6'h00) begin
								rsh_ff <= {pin_s, rsh_ff[7:1]};
							end
						end else begin
							tmr_ff <= tmr_ff - 1'b1;
						end
					end
					dci_pkg::LK_TX: begin
						if (tick) begin
							tmr_ff  <= bitp_ff - 11'h001;
							bitn_ff <= bitn_ff + 1'b1;
							tsh_ff  <= {1'b1, tsh_ff[9:1]};
							if (bitn_ff == dci_pkg::STOP_BIT) begin
								lk_ff <= dci_pkg::LK_IDLE;
								oe_ff <= 1'b0;
							end else begin
								oe_ff <= ~tsh_ff[1];
							end
						end else begin
							tmr_ff <= tmr_ff - 1'b1;
						end
					end
					dci_pkg::LK_BRK: begin
						if (tick) begin
							tmr_ff  <= bitp_ff - 11'h001;
							bitn_ff <= bitn_ff + 1'b1;
							if (bitn_ff == dci_pkg::BRK_LEN - 6'h01) begin
								lk_ff <= dci_pkg::LK_WAIT;
								oe_ff <= 1'b0;
							end
						end else begin
							tmr_ff <= tmr_ff - 1'b1;
						end
					end
					dci_pkg::LK_WAIT: begin
						// Host may hold its break longer than ours
						if (pin_s && pin_d_ff) begin
							lk_ff <= dci_pkg::LK_CAL;
						end
					end
					default: begin
						lk_ff <= dci_pkg::LK_CAL;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		pin_o_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Answer FIFO: the interpreter stalls while it is full

	dci_fifo #(
		.W (dci_pkg::FIFO_W),
		.D (dci_pkg::FIFO_D)
	) u_fifo (
		.mclk_i    (mclk_i),
		.srst_i    (srst_i),
		.flush_i   (err_ff),
		.in_vld_i  (push),
		.in_rdy_o  (f_in_rdy),
		.in_dat_i  (push_dat),
		.out_vld_o (f_out_vld),
		.out_rdy_i (tx_take),
		.out_dat_o (f_out_dat)
	);

	////////////////////////////////////////////////////////////////////////////
	// Command interpreter

	assign full     = ctl_ff[dci_pkg::CTL_HALT] && !read_protect_i;
	assign last_arg = (ci_ff == dci_pkg::CI_ARG) && rx_vld_ff && (need_ff == 2'h1);
	assign wr_ok    = ctl_ff[dci_pkg::CTL_HALT] && (!read_protect_i
		|| (addr_ff >= dci_pkg::FLASH_LO && addr_ff <= dci_pkg::FLASH_HI
		&& (addr_ff != dci_pkg::FLASH_CTL || rx_dat_ff == dci_pkg::MASS_ERASE)));

	always_comb begin
		push     = 1'b0;
		push_dat = rsp_ff[15:8];
		if (ci_ff == dci_pkg::CI_RSP) begin
			push = 1'b1;
		end else if (ci_ff == dci_pkg::CI_RDW) begin
			push     = 1'b1;
			push_dat = full ? reg_rdata_i : dci_pkg::ONES8;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i || err_ff) begin
			ci_ff    <= dci_pkg::CI_CMD;
			cmd_ff   <= '0;
			need_ff  <= '0;
			arg_ff   <= '0;
			cnt_ff   <= '0;
			addr_ff  <= '0;
			rsp_ff   <= '0;
			rsp_n_ff <= '0;
			reg_ff   <= '0;
			cpu_ff   <= '0;
		end else begin
			reg_ff.wr    <= 1'b0;
			reg_ff.rd    <= 1'b0;
			cpu_ff.pc_wr <= 1'b0;
			cpu_ff.step  <= 1'b0;
			cpu_ff.stuff <= 1'b0;
			cpu_ff.exec  <= 1'b0;
			case (ci_ff)
				dci_pkg::CI_CMD: begin
					if (rx_vld_ff) begin
						cmd_ff <= rx_dat_ff;
						case (rx_dat_ff)
							dci_pkg::CMD_REV: begin
								rsp_ff   <= dci_pkg::REV_VAL;
								rsp_n_ff <= 2'h2;
								ci_ff    <= dci_pkg::CI_RSP;
							end
							dci_pkg::CMD_STAT: begin
								rsp_ff   <= {status_i, 8'h00};
								rsp_n_ff <= 2'h1;
								ci_ff    <= dci_pkg::CI_RSP;
							end
							dci_pkg::CMD_RTC: begin
								if (ctl_ff[dci_pkg::CTL_HALT]) begin
									rsp_ff   <= rt_ff;
									rsp_n_ff <= 2'h2;
									ci_ff    <= dci_pkg::CI_RSP;
								end
							end
							dci_pkg::CMD_RCTL: begin
								rsp_ff   <= {ctl_ff, 8'h00};
								rsp_n_ff <= 2'h1;
								ci_ff    <= dci_pkg::CI_RSP;
							end
							dci_pkg::CMD_RPC: begin
								rsp_ff   <= full ? pc_i : dci_pkg::ONES16;
								rsp_n_ff <= 2'h2;
								ci_ff    <= dci_pkg::CI_RSP;
							end
							dci_pkg::CMD_WCTL, dci_pkg::CMD_STUFF: begin
								need_ff <= 2'h1;
								ci_ff   <= dci_pkg::CI_ARG;
							end
							dci_pkg::CMD_WPC: begin
								need_ff <= 2'h2;
								ci_ff   <= dci_pkg::CI_ARG;
							end
							dci_pkg::CMD_WREG, dci_pkg::CMD_RREG: begin
								need_ff <= 2'h3;
								ci_ff   <= dci_pkg::CI_ARG;
							end
							dci_pkg::CMD_STEP: begin
								cpu_ff.step <= full;
							end
							dci_pkg::CMD_EXEC: begin
								ci_ff <= dci_pkg::CI_EXEC;
							end
							default: begin
								ci_ff <= dci_pkg::CI_CMD;
							end
						endcase
					end
				end
				dci_pkg::CI_ARG: begin
					if (rx_vld_ff) begin
						arg_ff  <= {arg_ff[7:0], rx_dat_ff};
						need_ff <= need_ff - 1'b1;
						if (need_ff == 2'h1) begin
							ci_ff <= dci_pkg::CI_CMD;
							if (cmd_ff == dci_pkg::CMD_WPC) begin
								cpu_ff.pc    <= {arg_ff[7:0], rx_dat_ff};
								cpu_ff.pc_wr <= full;
							end else if (cmd_ff == dci_pkg::CMD_STUFF) begin
								cpu_ff.op    <= rx_dat_ff;
								cpu_ff.stuff <= full;
							end else if (cmd_ff == dci_pkg::CMD_WREG
								|| cmd_ff == dci_pkg::CMD_RREG) begin
								addr_ff <= arg_ff[11:0];
								cnt_ff  <= (rx_dat_ff == 8'h00) ? dci_pkg::SIZE_256
									: {1'b0, rx_dat_ff};
								ci_ff   <= (cmd_ff == dci_pkg::CMD_WREG) ? dci_pkg::CI_WR
									: dci_pkg::CI_RD;
							end
						end
					end
				end
				dci_pkg::CI_WR: begin
					if (rx_vld_ff) begin
						reg_ff.addr <= addr_ff;
						reg_ff.data <= rx_dat_ff;
						reg_ff.wr   <= wr_ok;
						addr_ff     <= addr_ff + 1'b1;
						cnt_ff      <= cnt_ff - 1'b1;
						if (cnt_ff == 9'h001) begin
							ci_ff <= dci_pkg::CI_CMD;
						end
					end
				end
				dci_pkg::CI_RD: begin
					// Only this process fills the FIFO, so room seen here holds next cycle
					if (f_in_rdy) begin
						reg_ff.addr <= addr_ff;
						reg_ff.rd   <= full;
						ci_ff       <= dci_pkg::CI_RDW;
					end
				end
				dci_pkg::CI_RDW: begin
					addr_ff <= addr_ff + 1'b1;
					cnt_ff  <= cnt_ff - 1'b1;
					ci_ff   <= (cnt_ff == 9'h001) ? dci_pkg::CI_CMD : dci_pkg::CI_RD;
				end
				dci_pkg::CI_RSP: begin
					if (f_in_rdy) begin
						rsp_ff   <= {rsp_ff[7:0], 8'h00};
						rsp_n_ff <= rsp_n_ff - 1'b1;
						if (rsp_n_ff == 2'h1) begin
							ci_ff <= dci_pkg::CI_CMD;
						end
					end
				end
				dci_pkg::CI_EXEC: begin
					if (rx_vld_ff) begin
						cpu_ff.op   <= rx_dat_ff;
						cpu_ff.exec <= full;
						if (!full) begin
							ci_ff <= dci_pkg::CI_CMD;
						end
					end else if (exec_done_i) begin
						ci_ff <= dci_pkg::CI_CMD;
					end
				end
				default: begin
					ci_ff <= dci_pkg::CI_CMD;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Debug control register and runtime counter

	always_comb begin
		nxt_ctl = ctl_ff;
		if (last_arg && cmd_ff == dci_pkg::CMD_WCTL) begin
			nxt_ctl = rx_dat_ff & dci_pkg::CTL_WMASK;
			if (read_protect_i && ctl_ff[dci_pkg::CTL_HALT]) begin
				nxt_ctl[dci_pkg::CTL_HALT] = 1'b1;
			end
		end
		// A breakpoint in the same cycle as a write still halts
		if (bkpt_i && ctl_ff[dci_pkg::CTL_BRKEN]) begin
			nxt_ctl[dci_pkg::CTL_HALT] = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ctl_ff <= dci_pkg::CTL_RST;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// Never overwritten by commands here, which the relaxed counter contract allows
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			halt_d_ff <= 1'b0;
			rt_ff     <= '0;
		end else begin
			halt_d_ff <= ctl_ff[dci_pkg::CTL_HALT];
			if (halt_d_ff && !ctl_ff[dci_pkg::CTL_HALT]) begin
				rt_ff <= '0;
			end else if (!ctl_ff[dci_pkg::CTL_HALT] && rt_ff != dci_pkg::ONES16) begin
				rt_ff <= rt_ff + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign debug_pin_o    = pin_o_ff;
	assign debug_pin_oe_o = oe_ff;
	assign ctl_o          = ctl_ff;
	assign reg_o          = reg_ff;
	assign cpu_o          = cpu_ff;

endmodule : dci_top

// *** bench/dci_checker.sv ***
// Port assertions of the debug command interpreter.
// Assumes one clock domain and the synchronous active-high reset.
module dci_checker (
	input wire logic              mclk_i,
	input wire logic              srst_i,
	input wire logic              read_protect_i,
	input wire logic              debug_pin_o,
	input wire logic [7:0]        ctl_o,
	input wire dci_pkg::dci_reg_t reg_o,
	input wire dci_pkg::dci_cpu_t cpu_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	sequence wr_once_s;
		reg_o.wr ##1 !reg_o.wr;
	endsequence
	// Protect held over two edges, so a short reset cannot fake a fall
	sequence prot_held_s;
		read_protect_i && $past(read_protect_i) && !$past(srst_i);
	endsequence
	pin_low_a: assert property (debug_pin_o == 1'b0)
		else $error("debug pin data not low");
	ctl_resv_a: assert property (ctl_o[4:1] == 4'h0)
		else $error("reserved control bits set");
	wr_pulse_a: assert property (reg_o.wr |-> wr_once_s)
		else $error("register write strobe too long");
	wr_halt_a: assert property (reg_o.wr || reg_o.rd |-> ctl_o[7])
		else $error("register access while running");
	wr_prot_a: assert property (read_protect_i && reg_o.wr |->
		reg_o.addr inside {[dci_pkg::FLASH_LO:dci_pkg::FLASH_HI]} &&
		(reg_o.addr != dci_pkg::FLASH_CTL || reg_o.data == dci_pkg::MASS_ERASE))
		else $error("protected register write let through");
	rd_prot_a: assert property (read_protect_i |-> !reg_o.rd)
		else $error("register read under protection");
	halt_keep_a: assert property (prot_held_s |-> !$fell(ctl_o[7]))
		else $error("halted flag cleared under protection");
	cpu_prot_a: assert property (read_protect_i |-> !(cpu_o.pc_wr || cpu_o.step ||
		cpu_o.stuff || cpu_o.exec)) else $error("cpu command under protection");
	pc_halt_a: assert property (cpu_o.pc_wr |-> ctl_o[7])
		else $error("program counter written while running");
	cpu_halt_a: assert property (cpu_o.step || cpu_o.stuff || cpu_o.exec |-> ctl_o[7])
		else $error("cpu command while running");
endmodule : dci_checker

// *** bench/dci_host.sv ***
// Debug host model: drives and reads the open-drain debug pin.
// Assumes a pull-up on the wire; pull_o high pulls it low.
module dci_host #(
	parameter int P = 16
) (
	input wire logic clk_i,
	input wire logic pin_i,
	output logic     pull_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pull_o = 1'b0;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			pull_o = ~f[i];
			repeat (P) @(negedge clk_i);
		end
	endtask : send_byte
	// Unknown comes back if no start bit shows, so the caller's compare fails
	task automatic recv_byte(output logic [7:0] b);
		int i;
		b = 'x;
		for (i = 0; i < 4000 && pin_i; i++) @(negedge clk_i);
		if (!pin_i) begin
			repeat (P / 2) @(negedge clk_i);
			for (int k = 0; k < 8; k++) begin
				repeat (P) @(negedge clk_i);
				b[k] = pin_i;
			end
			repeat (P) @(negedge clk_i);
		end
	endtask : recv_byte
	task automatic cal();
		send_byte(8'h80);
	endtask : cal
	task automatic brk(input int n);
		pull_o = 1'b1;
		repeat (n * P) @(negedge clk_i);
		pull_o = 1'b0;
	endtask : brk
endmodule : dci_host

// *** bench/dci_bench.sv ***
// Self-checking bench of the debug command interpreter.
// Assumes the host model and checker are compiled before this file.
module dci_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 16;
	logic              mclk_i;
	logic              srst_i;
	logic              pull;
	logic              prot;
	logic              bkpt;
	logic              done;
	logic [7:0]        status;
	logic [15:0]       pc;
	logic [7:0]        rdat;
	logic              pin_o;
	logic              pin_oe;
	logic [7:0]        ctl;
	dci_pkg::dci_reg_t rg;
	dci_pkg::dci_cpu_t cpu;
	wire logic         pin = ~(pin_oe | pull);
	int                n_fail = 0;
	int                compares = 0;
	int                n_wr = 0;
	int                n_pc = 0;
	int                n_cpu = 0;
	logic [7:0]        op;
	logic [11:0]       wa;
	logic [7:0]        wd;
	logic [15:0]       pcw;
	assign rdat = rg.addr[7:0] ^ 8'h3C;
	dci_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .debug_pin_i(pin), .read_protect_i(prot),
		.bkpt_i(bkpt), .exec_done_i(done), .status_i(status), .pc_i(pc), .reg_rdata_i(rdat),
		.debug_pin_o(pin_o), .debug_pin_oe_o(pin_oe), .ctl_o(ctl), .reg_o(rg), .cpu_o(cpu));
	dci_host #(.P(P)) host (.clk_i(mclk_i), .pin_i(pin), .pull_o(pull));
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	// Sampled mid-cycle so each one-cycle strobe is seen exactly once
	always @(negedge mclk_i) begin
		if (rg.wr === 1'b1) begin
			n_wr++;
			wa = rg.addr;
			wd = rg.data;
		end
		if (cpu.step === 1'b1 || cpu.stuff === 1'b1 || cpu.exec === 1'b1) begin
			n_cpu++;
			op = cpu.op;
		end
		if (cpu.pc_wr === 1'b1) begin
			n_pc++;
			pcw = cpu.pc;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic snd(input logic [7:0] q[]);
		foreach (q[i]) host.send_byte(q[i]);
		repeat (2) @(negedge mclk_i);
	endtask : snd
	task automatic rx16(output logic [15:0] v);
		host.recv_byte(v[15:8]);
		host.recv_byte(v[7:0]);
		// Let the answer's stop bit end before the host talks again
		repeat (P) @(negedge mclk_i);
	endtask : rx16
	task automatic rx8(output logic [15:0] v);
		v[15:8] = 8'h00;
		host.recv_byte(v[7:0]);
		repeat (P) @(negedge mclk_i);
	endtask : rx8
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_idle();
		logic [15:0] v;
		snd('{8'h00});
		rx16(v);
		chk("revision", v, dci_pkg::REV_VAL);
		status = 8'hA5;
		snd('{8'h01, 8'h03, 8'h02});
		rx8(v);
		chk("status", v, 16'h00A5);
		snd('{8'h07});
		rx16(v);
		chk("pc idle", v, 16'hFFFF);
		snd('{8'h08, 8'h00, 8'h10, 8'h01, 8'h77, 8'h06, 8'h12, 8'h34});
		chk("idle reg writes", 16'(n_wr), 16'h0000);
		chk("idle pc writes", 16'(n_pc), 16'h0000);
		$display("test idle done");
	endtask : t_idle
	task automatic t_halt();
		logic [15:0] v;
		snd('{8'h04, 8'h80});
		chk("ctl", {8'h00, ctl}, 16'h0080);
		snd('{8'h05});
		rx8(v);
		chk("ctl read", v, 16'h0080);
		pc = 16'h1234;
		snd('{8'h07});
		rx16(v);
		chk("pc read", v, 16'h1234);
		snd('{8'h06, 8'hAB, 8'hCD});
		chk("pc write", pcw, 16'hABCD);
		snd('{8'h08, 8'h01, 8'h23, 8'h02, 8'h5A, 8'hA5});
		chk("reg writes", 16'(n_wr), 16'h0002);
		chk("reg last", {wa, wd[3:0]}, 16'h1245);
		snd('{8'h09, 8'h00, 8'h40, 8'h01});
		rx8(v);
		chk("reg read", v, 16'h007C);
		$display("test halted done");
	endtask : t_halt
	task automatic t_cpu();
		logic [15:0] v;
		logic [15:0] w;
		snd('{8'h10, 8'h11, 8'h3E, 8'h12, 8'h8F});
		done = 1'b1;
		@(negedge mclk_i);
		done = 1'b0;
		chk("cpu strobes", 16'(n_cpu), 16'h0003);
		chk("exec op", {8'h00, op}, 16'h008F);
		snd('{8'h04, 8'h40});
		chk("ctl run", {8'h00, ctl}, 16'h0040);
		bkpt = 1'b1;
		@(negedge mclk_i);
		bkpt = 1'b0;
		@(negedge mclk_i);
		chk("breakpoint halt", {8'h00, ctl}, 16'h00C0);
		snd('{8'h03});
		rx16(v);
		snd('{8'h03});
		rx16(w);
		chk("rtc frozen", w, v);
		chk("rtc ran", {15'h0000, v == 16'h0000}, 16'h0000);
		$display("test cpu done");
	endtask : t_cpu
	task automatic t_prot();
		logic [15:0] v;
		prot = 1'b1;
		snd('{8'h07});
		rx16(v);
		chk("pc protected", v, 16'hFFFF);
		snd('{8'h09, 8'h00, 8'h40, 8'h01});
		rx8(v);
		chk("reg read protected", v, 16'h00FF);
		snd('{8'h04, 8'h00, 8'h05});
		rx8(v);
		chk("halt kept", v, 16'h0080);
		snd('{8'h10, 8'h12, 8'h8F, 8'h06, 8'h12, 8'h34});
		chk("cpu protected", 16'(n_cpu), 16'h0003);
		chk("pc write protected", 16'(n_pc), 16'h0001);
		snd('{8'h08, 8'h0F, 8'hF8, 8'h01, 8'h95, 8'h08, 8'h0F, 8'hF8, 8'h01, 8'h12});
		snd('{8'h08, 8'h00, 8'h10, 8'h01, 8'h55});
		chk("protected writes", 16'(n_wr), 16'h0003);
		chk("erase data", {wa, wd[3:0]}, 16'hFF85);
		prot = 1'b0;
		$display("test protect done");
	endtask : t_prot
	task automatic t_break();
		logic [15:0] v;
		host.brk(12);
		repeat (10 * P) @(negedge mclk_i);
		chk("break echo", {15'h0000, pin_oe}, 16'h0001);
		for (int i = 0; i < 60 * P && !pin; i++) @(negedge mclk_i);
		repeat (8) @(negedge mclk_i);
		host.cal();
		snd('{8'h05});
		rx8(v);
		chk("ctl after break", v, 16'h0080);
		$display("test break done");
	endtask : t_break
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test
	// Whole run is near 15000 cycles; over twice that marks a hang
	initial begin
		repeat (40000) @(posedge mclk_i);
		n_fail++;
		finish_test();
	end
	initial begin
		srst_i = 1'b1;
		prot = 1'b0;
		bkpt = 1'b0;
		done = 1'b0;
		status = 8'h00;
		pc = 16'h0000;
		repeat (20) @(negedge mclk_i);
		srst_i = 1'b0;
		@(negedge mclk_i);
		host.cal();
		t_idle();
		t_halt();
		t_cpu();
		t_prot();
		t_break();
		finish_test();
	end
endmodule : dci_bench
bind dci_top dci_checker chk_u (.mclk_i(mclk_i), .srst_i(srst_i), .read_protect_i(read_protect_i),
	.debug_pin_o(debug_pin_o), .ctl_o(ctl_o), .reg_o(reg_o), .cpu_o(cpu_o));
